// [rtl/fault_sup_pkg.sv]
// package: register map, field positions and timing of the fault supervisor
package fault_sup_pkg;
  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CP_CFG = 8'h0b;
  localparam logic [7:0] ADDR_RECOVERY_CFG = 8'h0f;
  localparam logic [7:0] ADDR_START_CFG = 8'h10;
  localparam logic [7:0] ADDR_OC_MASK_CFG = 8'h12;
  localparam logic [7:0] ADDR_LOCK_CFG = 8'h13;
  localparam logic [7:0] ADDR_RESTART_CFG = 8'h14;
  localparam logic [7:0] ADDR_SPEED_CFG = 8'h15;
  localparam logic [7:0] ADDR_OC_LEVEL_CFG = 8'h17;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int CP_MASK_BIT = 1;
  localparam int LATCH_BIT = 2;
  localparam int START_DIS_BIT = 7;
  localparam int OC_MASK_BIT = 3;
  localparam int TSD_MASK_BIT = 0;
  localparam int ALERT_INV_BIT = 1;
  localparam int BRAKE_BIT = 2;
  localparam int RESTART_SEL_LSB = 5;
  localparam int OVSPD_SEL_LSB = 2;
  localparam int FORCED_SEL_LSB = 0;
  localparam int OC_LVL_BIT = 7;
  // status flag positions
  localparam int ST_CP = 5;
  localparam int ST_OT = 4;
  localparam int ST_OC = 3;
  localparam int ST_OV = 2;
  localparam int ST_UN = 1;
  localparam int ST_SF = 0;
  localparam int NFLAG = 6;
  // synchronised comparator lanes
  localparam int AN_UV = 0;
  localparam int AN_CP = 1;
  localparam int AN_OT = 2;
  localparam int AN_OC = 3;
  localparam int AN_STBY = 4;
  localparam int AN_W = 5;
  localparam int GATES = 3;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 10;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int START_ROUNDS = 4;
  localparam int CNT_W = 20;
  localparam int OVSPD_LIMIT_HZ [3] = '{750, 1500, 3000};
  localparam int FORCED_RATE_DHZ [4] = '{16, 32, 64, 128}; // tenths of hertz
  localparam int RESTART_DELAY_MS [8] = '{0, 500, 1000, 1500, 2000, 4000, 7000, 10000};

  typedef enum logic [3:0] {
    M_NORMAL = 4'b0001,
    M_ERROR = 4'b0010,
    M_STANDBY = 4'b0100,
    M_LOCKOUT = 4'b1000
  } mode_t;

  // longest period in ticks still counted as overspeed, rounded down
  function automatic logic [CNT_W-1:0] ovspd_ticks(input logic [1:0] sel);
    int idx;
    idx = (sel == 2'd3) ? 0 : int'(sel);
    return CNT_W'(1_000_000 / (OVSPD_LIMIT_HZ[idx] * TICK_US));
  endfunction

  // period in ticks beyond which speed is too low, rounded up
  function automatic logic [CNT_W-1:0] unspd_ticks(input logic [1:0] sel);
    int d;
    d = FORCED_RATE_DHZ[sel] * TICK_US;
    return CNT_W'((10_000_000 + d - 1) / d);
  endfunction

  // restart delay in ticks
  function automatic logic [CNT_W-1:0] restart_ticks(input logic [2:0] sel);
    return CNT_W'(RESTART_DELAY_MS[sel] * (1000 / TICK_US));
  endfunction
endpackage

// [rtl/analog_if.sv]
// carrier between the supervisor and its comparator synchroniser
`timescale 1ns/1ps
interface analog_if #(
  parameter int W = 5
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport core_side (output raw, input sync);
  modport sync_side (input raw, output sync);
endinterface

// [rtl/level_sync.sv]
// two-flop synchroniser for asynchronous comparator levels
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  analog_if.sync_side aif
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // first stage feeds only the second
  always_comb begin
    s_d.meta = aif.raw;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign aif.sync = s_q.stable;
endmodule

// [rtl/motor_fault_supervisor.sv]
// fault supervisor: error mode, gate output override, recovery and status
//
// Contract
// [R01] overspeed reached: error mode, all gates off
// [R02] speed field 3:2 picks overspeed limit
// [R03] speed below forced rate: error mode
// [R04] speed field 1:0 picks forced rate
// [R05] four forced rounds, no sensorless: startup failure
// [R06] stall brake bit picks off or brake
// [R07] start error disable bit suppresses startup failure
// [R08] supply undervoltage stops all operation
// [R09] overcurrent: all gates off, error mode
// [R10] overcurrent level bit picks reference
// [R11] overcurrent mask bit disables detection
// [R12] charge pump low: gates high impedance
// [R13] charge pump mask bit disables detection
// [R14] overtemperature: gates off, automatic return
// [R15] thermal mask bit disables shutdown
// [R16] standby or power off clears error, Hi-Z
// [R17] latch bit: hold error until release
// [R18] automatic restart after selected delay
// [R19] open-drain alert with selectable polarity
// [R20] status register flags each fault cause
// [R21] comparator levels synchronised before use
`timescale 1ns/1ps
module motor_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int TICK_CYCLES = fault_sup_pkg::TICK_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  input wire logic supply_undervoltage_lock,
  input wire logic charge_pump_undervoltage,
  input wire logic overtemp_detect,
  input wire logic overcurrent_detect,
  input wire logic standby_pin,
  input wire logic speed_cmd_zero,
  input wire logic drive_sensorless,
  input wire logic rot_pulse,
  input wire logic forced_rot_pulse,
  input wire logic [fault_sup_pkg::GATES-1:0] gate_high_req,
  input wire logic [fault_sup_pkg::GATES-1:0] gate_low_req,
  output logic [fault_sup_pkg::GATES-1:0] high_side_gate_outputs,
  output logic [fault_sup_pkg::GATES-1:0] low_side_gate_outputs,
  output logic gate_drive_enable,
  output logic overcurrent_ref_sel,
  output logic operation_stop,
  output logic alert_out,
  output logic alert_oe
);
  import fault_sup_pkg::*;

  typedef struct packed {
    mode_t mode;
    logic [NFLAG-1:0] flags;
    logic [CNT_W-1:0] per_cnt;
    logic per_ok;
    logic [2:0] st_cnt;
    logic [CNT_W-1:0] rs_cnt;
    logic [15:0] tk_cnt;
    logic tick;
    logic [7:0] r_cp;
    logic [7:0] r_rec;
    logic [7:0] r_start;
    logic [7:0] r_ocm;
    logic [7:0] r_lock;
    logic [7:0] r_rdly;
    logic [7:0] r_spd;
    logic [7:0] r_ocl;
    logic [GATES-1:0] hi;
    logic [GATES-1:0] lo;
    logic oe;
    logic stop;
    logic al_oe;
    logic [7:0] rd;
  } state_t;

  localparam state_t S_RST = '{mode: M_NORMAL, default: '0};

  state_t s_q;
  state_t s_d;

  analog_if #(.W(AN_W)) aif ();

  // comparator levels into the clock domain
  assign aif.raw = {standby_pin, overcurrent_detect, overtemp_detect,
                    charge_pump_undervoltage, supply_undervoltage_lock};

  level_sync #(.W(AN_W)) u_sync ( // see [R21]
    .core_clk(core_clk),
    .reset_n(reset_n),
    .aif(aif.sync_side)
  );

  logic uv;
  logic stby;
  logic cp_f;
  logic ot_f;
  logic oc_f;
  logic held;
  logic [1:0] ovspd_sel;
  logic [1:0] forced_sel;
  logic ov_ev;
  logic un_ev;
  logic st_ev;
  logic [NFLAG-1:0] ev;
  logic release_ok;
  logic lock_only;

  // supply and standby levels, masked fault causes
  assign uv = aif.sync[AN_UV]; // see [R08]
  assign stby = aif.sync[AN_STBY];
  assign cp_f = aif.sync[AN_CP] & ~s_q.r_cp[CP_MASK_BIT]; // see [R13]
  assign ot_f = aif.sync[AN_OT] & ~s_q.r_lock[TSD_MASK_BIT]; // see [R15]
  assign oc_f = aif.sync[AN_OC] & ~s_q.r_ocm[OC_MASK_BIT]; // see [R11]
  assign held = cp_f | ot_f | oc_f;
  assign ovspd_sel = s_q.r_spd[OVSPD_SEL_LSB +: 2];
  assign forced_sel = s_q.r_spd[FORCED_SEL_LSB +: 2];

  // speed and startup events
  assign ov_ev = rot_pulse & drive_sensorless & s_q.per_ok & (ovspd_sel != 2'b11)
               & (s_q.per_cnt <= ovspd_ticks(ovspd_sel)); // see [R01] [R02]
  assign un_ev = drive_sensorless
               & (s_q.per_cnt > unspd_ticks(forced_sel)); // see [R03] [R04]
  assign st_ev = forced_rot_pulse & ~drive_sensorless
               & (s_q.st_cnt == 3'(START_ROUNDS - 1))
               & ~s_q.r_start[START_DIS_BIT]; // see [R05] [R07]

  // speed events only count while driving
  always_comb begin
    ev = '0;
    if (s_q.mode == M_NORMAL || s_q.mode == M_ERROR) begin
      ev[ST_CP] = cp_f; // see [R12]
      ev[ST_OT] = ot_f; // see [R14]
      ev[ST_OC] = oc_f; // see [R09]
    end
    if (s_q.mode == M_NORMAL) begin
      ev[ST_OV] = ov_ev;
      ev[ST_UN] = un_ev;
      ev[ST_SF] = st_ev;
    end
  end

  // release by zero speed command or by elapsed restart delay
  assign release_ok = speed_cmd_zero
                    | (~s_q.r_rec[LATCH_BIT] // see [R17]
                       & (s_q.rs_cnt >= restart_ticks(s_q.r_rdly[RESTART_SEL_LSB +: 3]))); // see [R18]

  // next state
  always_comb begin
    s_d = s_q;
    // base tick for period and delay counters
    s_d.tick = 1'b0;
    if (s_q.tk_cnt >= 16'(TICK_CYCLES - 1)) begin
      s_d.tk_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tk_cnt = s_q.tk_cnt + 16'd1;
    end
    // register writes
    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_CP_CFG: s_d.r_cp = reg_wr_data;
        ADDR_RECOVERY_CFG: s_d.r_rec = reg_wr_data;
        ADDR_START_CFG: s_d.r_start = reg_wr_data;
        ADDR_OC_MASK_CFG: s_d.r_ocm = reg_wr_data;
        ADDR_LOCK_CFG: s_d.r_lock = reg_wr_data;
        ADDR_RESTART_CFG: s_d.r_rdly = reg_wr_data;
        ADDR_SPEED_CFG: s_d.r_spd = reg_wr_data;
        ADDR_OC_LEVEL_CFG: s_d.r_ocl = reg_wr_data;
        default: s_d.r_cp = s_q.r_cp;
      endcase
    end
    // rotation period measurement
    if (s_q.mode == M_NORMAL && drive_sensorless) begin
      if (rot_pulse) begin
        s_d.per_cnt = '0;
        s_d.per_ok = 1'b1;
      end else if (s_q.tick && s_q.per_cnt != '1) begin
        s_d.per_cnt = s_q.per_cnt + CNT_W'(1);
      end
    end else begin
      s_d.per_cnt = '0;
      s_d.per_ok = 1'b0;
    end
    // forced commutation rounds
    if (s_q.mode == M_NORMAL && !drive_sensorless) begin
      if (forced_rot_pulse && s_q.st_cnt != 3'(START_ROUNDS - 1)) begin
        s_d.st_cnt = s_q.st_cnt + 3'd1;
      end
    end else begin
      s_d.st_cnt = '0;
    end
    // mode sequence
    s_d.flags = s_q.flags | ev; // see [R20]
    unique case (s_q.mode)
      M_NORMAL: begin
        if (|ev) begin
          s_d.mode = M_ERROR;
          s_d.rs_cnt = '0;
        end
      end
      M_ERROR: begin
        if (s_q.tick && s_q.rs_cnt != '1) begin
          s_d.rs_cnt = s_q.rs_cnt + CNT_W'(1);
        end
        if (release_ok && !held && ev == '0) begin
          s_d.mode = M_NORMAL;
          s_d.flags = '0;
        end
      end
      M_STANDBY: begin
        if (!stby) begin
          s_d.mode = M_NORMAL;
        end
      end
      M_LOCKOUT: begin
        if (!uv) begin
          s_d.mode = M_NORMAL;
        end
      end
    endcase
    // standby clears error mode
    if (stby) begin
      s_d.mode = M_STANDBY; // see [R16]
      s_d.flags = '0;
    end
    // supply lockout overrides everything
    if (uv) begin
      s_d.mode = M_LOCKOUT; // see [R08]
      s_d.flags = '0;
    end
    // gate drive from the next mode
    lock_only = (s_d.flags[ST_CP:ST_OV] == '0) && (s_d.flags[ST_UN:ST_SF] != '0);
    s_d.stop = (s_d.mode == M_LOCKOUT);
    unique case (s_d.mode)
      M_NORMAL: begin
        s_d.hi = gate_high_req;
        s_d.lo = gate_low_req;
        s_d.oe = 1'b1;
      end
      M_ERROR: begin
        s_d.hi = '0;
        s_d.lo = (lock_only && s_d.r_lock[BRAKE_BIT]) ? '1 : '0; // see [R06]
        s_d.oe = ~s_d.flags[ST_CP]; // see [R12]
      end
      M_STANDBY: begin
        s_d.hi = '0;
        s_d.lo = '0;
        s_d.oe = 1'b0;
      end
      M_LOCKOUT: begin
        s_d.hi = '0;
        s_d.lo = '0;
        s_d.oe = 1'b0;
      end
    endcase
    // open drain: released is high, driven is low
    s_d.al_oe = ((s_d.mode == M_ERROR) == s_d.r_lock[ALERT_INV_BIT]); // see [R19]
    // register read, one cycle after the address
    case (reg_addr)
      ADDR_STATUS: s_d.rd = {2'b00, s_q.flags}; // see [R20]
      ADDR_CP_CFG: s_d.rd = s_q.r_cp;
      ADDR_RECOVERY_CFG: s_d.rd = s_q.r_rec;
      ADDR_START_CFG: s_d.rd = s_q.r_start;
      ADDR_OC_MASK_CFG: s_d.rd = s_q.r_ocm;
      ADDR_LOCK_CFG: s_d.rd = s_q.r_lock;
      ADDR_RESTART_CFG: s_d.rd = s_q.r_rdly;
      ADDR_SPEED_CFG: s_d.rd = s_q.r_spd;
      ADDR_OC_LEVEL_CFG: s_d.rd = s_q.r_ocl;
      default: s_d.rd = REG_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state, alert_out tied low
  assign high_side_gate_outputs = s_q.hi;
  assign low_side_gate_outputs = s_q.lo;
  assign gate_drive_enable = s_q.oe;
  assign operation_stop = s_q.stop;
  assign overcurrent_ref_sel = s_q.r_ocl[OC_LVL_BIT]; // see [R10]
  assign alert_out = 1'b0;
  assign alert_oe = s_q.al_oe;
  assign reg_rd_data = s_q.rd;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ovspd_off_a: assert property ( // see [R01]
    s_q.mode == M_NORMAL && ov_ev && !uv && !stby
    |=> s_q.mode == M_ERROR && s_q.flags[ST_OV]
        && high_side_gate_outputs == '0 && low_side_gate_outputs == '0)
    else $error("overspeed did not turn gates off");

  ovspd_none_a: assert property ( // see [R02]
    s_q.r_spd[OVSPD_SEL_LSB +: 2] == 2'b11 |-> !ev[ST_OV])
    else $error("overspeed seen while disabled");

  underspeed_a: assert property ( // see [R03]
    s_q.mode == M_NORMAL && drive_sensorless && !uv && !stby
    && s_q.per_cnt > unspd_ticks(s_q.r_spd[FORCED_SEL_LSB +: 2])
    |=> s_q.mode == M_ERROR && s_q.flags[ST_UN])
    else $error("underspeed missed");

  start_fail_a: assert property ( // see [R05]
    s_q.mode == M_NORMAL && forced_rot_pulse && !drive_sensorless && !uv && !stby
    && s_q.st_cnt == 3'(START_ROUNDS - 1) && !s_q.r_start[START_DIS_BIT]
    |=> s_q.flags[ST_SF] && s_q.mode == M_ERROR)
    else $error("startup failure missed");

  start_dis_a: assert property ( // see [R07]
    s_q.r_start[START_DIS_BIT] |-> !ev[ST_SF])
    else $error("startup failure while disabled");

  stall_brake_a: assert property ( // see [R06]
    s_q.mode == M_ERROR && s_q.flags[ST_CP:ST_OV] == '0 && s_q.r_lock[BRAKE_BIT]
    |-> low_side_gate_outputs == '1 && high_side_gate_outputs == '0)
    else $error("short brake not applied");

  uv_stop_a: assert property ( // see [R08]
    uv |=> operation_stop && !gate_drive_enable && s_q.flags == '0)
    else $error("undervoltage did not stop operation");

  oc_mask_a: assert property ( // see [R11]
    s_q.r_ocm[OC_MASK_BIT] |-> !ev[ST_OC])
    else $error("overcurrent seen while masked");

  cp_hiz_a: assert property ( // see [R12]
    s_q.mode == M_ERROR && s_q.flags[ST_CP] |-> !gate_drive_enable)
    else $error("gates driven during charge pump low");

  standby_clr_a: assert property ( // see [R16]
    stby && !uv |=> s_q.mode == M_STANDBY && s_q.flags == '0 && !gate_drive_enable)
    else $error("standby did not clear error mode");

  latch_hold_a: assert property ( // see [R17]
    s_q.mode == M_ERROR && s_q.r_rec[LATCH_BIT] && !speed_cmd_zero && !stby && !uv
    |=> s_q.mode == M_ERROR)
    else $error("latched error left without release");

  restart_wait_a: assert property ( // see [R18]
    s_q.mode == M_ERROR && !speed_cmd_zero && !stby && !uv
    && s_q.rs_cnt < restart_ticks(s_q.r_rdly[RESTART_SEL_LSB +: 3])
    |=> s_q.mode == M_ERROR)
    else $error("error left before restart delay");

  alert_pol_a: assert property ( // see [R19]
    $past(reset_n) |-> alert_oe == ((s_q.mode == M_ERROR) == s_q.r_lock[ALERT_INV_BIT]))
    else $error("alert polarity wrong");

  error_entry_c: cover property (s_q.mode == M_NORMAL ##1 s_q.mode == M_ERROR);
  brake_c: cover property (s_q.mode == M_ERROR && low_side_gate_outputs == '1);
  auto_exit_c: cover property (
    s_q.mode == M_ERROR && !s_q.r_rec[LATCH_BIT] ##1 s_q.mode == M_NORMAL);
endmodule

// [verification/inverter_model.sv]
// external six-switch inverter as seen from its shunt resistor
`timescale 1ns/1ps
module inverter_model (
  input wire logic [2:0] high_gate,
  input wire logic [2:0] low_gate,
  input wire logic drive_en,
  input wire logic load_surge,
  output logic shunt_over
);
  // shoot-through or a commanded load surge lifts the shunt over the reference
  assign shunt_over = load_surge | (drive_en & |(high_gate & low_gate));
endmodule

// [verification/tb_top.sv]
// self-checking bench for the fault supervisor with its inverter partner
`timescale 1ns/1ps
module tb_top;
  import fault_sup_pkg::*;
  localparam int TK = 1;
  logic core_clk, reset_n, reg_wr_en, uv, cp, ot, surge, stby, zero, sens, rot, forced, oc;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rv;
  logic [2:0] gh, gl, hi, lo;
  logic gate_en, ref_sel, op_stop, al_out, al_oe, alert_pin;
  logic [31:0] r;
  int bad_count, checks, cyc, seed, inv, lim;
  logic [7:0] maddr [8] = '{8'h0b, 8'h0f, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h17};
  logic [7:0] mk_addr [3] = '{ADDR_OC_MASK_CFG, ADDR_LOCK_CFG, ADDR_CP_CFG};
  int mk_bit [3] = '{OC_MASK_BIT, TSD_MASK_BIT, CP_MASK_BIT};
  int flg [3] = '{ST_OC, ST_OT, ST_CP};
  int kind [3] = '{1, 1, 3};

  // open-drain alert line with a pull-up
  assign alert_pin = al_oe ? al_out : 1'b1;

  motor_fault_supervisor #(.TICK_CYCLES(TK)) u_motor_fault_supervisor (
    .core_clk(core_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .supply_undervoltage_lock(uv),
    .charge_pump_undervoltage(cp), .overtemp_detect(ot), .overcurrent_detect(oc),
    .standby_pin(stby), .speed_cmd_zero(zero), .drive_sensorless(sens), .rot_pulse(rot),
    .forced_rot_pulse(forced), .gate_high_req(gh), .gate_low_req(gl),
    .high_side_gate_outputs(hi), .low_side_gate_outputs(lo), .gate_drive_enable(gate_en),
    .overcurrent_ref_sel(ref_sel), .operation_stop(op_stop), .alert_out(al_out),
    .alert_oe(al_oe)
  );
  inverter_model u_inverter_model (
    .high_gate(hi), .low_gate(lo), .drive_en(gate_en), .load_surge(surge), .shunt_over(oc)
  );

  // clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out;
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
    rv = reg_rd_data;
  endtask

  // model: 0 normal, 1 all off, 2 brake, 3 high impedance, 4 supply lockout
  function automatic logic [7:0] exp_out(input int m, input logic [2:0] h, input logic [2:0] l);
    case (m)
      0: return {2'b01, h, l};
      1: return 8'h40;
      2: return 8'h47;
      3: return 8'h00;
      default: return 8'h80;
    endcase
  endfunction

  task automatic look(input int m, input bit e, input logic [7:0] st);
    @(negedge core_clk);
    chk({op_stop, gate_en, hi, lo}, exp_out(m, gh, gl));
    if (m != 4) begin
      chk({7'h0, alert_pin}, {7'h0, e ^ inv[0]});
      rd(ADDR_STATUS);
      chk(rv, st);
    end
    // hand back on a rising edge so later stimulus starts there
    @(posedge core_clk);
  endtask

  task automatic newreq;
    r = $random(seed);
    @(posedge core_clk);
    gh <= r[2:0];
    gl <= ~r[2:0] & r[5:3];
    tick(2);
  endtask

  task automatic rst;
    @(posedge core_clk);
    reset_n <= 1'b0;
    {uv, cp, ot, surge, stby, zero, sens, rot, forced} <= '0;
    inv = 0;
    tick(5);
    reset_n <= 1'b1;
  endtask

  task automatic cause(input int i, input logic v);
    @(posedge core_clk);
    case (i)
      0: surge <= v;
      1: ot <= v;
      2: cp <= v;
      default: uv <= v;
    endcase
    tick(6);
  endtask

  task automatic pulse(input bit f, input int gap);
    @(posedge core_clk);
    if (f)
      forced <= 1'b1;
    else
      rot <= 1'b1;
    @(posedge core_clk);
    forced <= 1'b0;
    rot <= 1'b0;
    tick(gap - 2);
  endtask

  // main sequence
  initial begin
    seed = 39;
    reset_n = 1'b0;
    {reg_wr_en, reg_addr, reg_wr_data, gh, gl} = '0;
    {uv, cp, ot, surge, stby, zero, sens, rot, forced} = '0;
    tick(5);
    reset_n <= 1'b1;
    foreach (maddr[k]) begin
      rd(maddr[k]);
      chk(rv, REG_RESET);
      r = $random(seed);
      wr(maddr[k], r[7:0]);
      rd(maddr[k]);
      chk(rv, r[7:0]);
    end
    chk({7'h0, ref_sel}, {7'h0, r[7]});
    // flip the level bit so both references are seen
    wr(ADDR_OC_LEVEL_CFG, ~r[7:0]);
    @(negedge core_clk);
    chk({7'h0, ref_sel}, {7'h0, ~r[7]});
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS);
    chk(rv, 8'h00);
    wr(8'h30, 8'h5a);
    rd(8'h30);
    chk(rv, 8'h00);
    rst;
    repeat (4) begin
      newreq;
      look(0, 0, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      rst;
      wr(mk_addr[i], 8'h01 << mk_bit[i]);
      cause(i, 1'b1);
      look(0, 0, 8'h00);
      wr(mk_addr[i], 8'h00);
      tick(4);
      look(kind[i], 1, 8'h01 << flg[i]);
      cause(i, 1'b0);
      look(0, 0, 8'h00);
    end
    rst;
    wr(ADDR_RECOVERY_CFG, 8'h04);
    wr(ADDR_LOCK_CFG, 8'h02);
    inv = 1;
    cause(1, 1'b1);
    cause(1, 1'b0);
    tick(20);
    look(1, 1, 8'h10);
    zero <= 1'b1;
    tick(4);
    zero <= 1'b0;
    tick(2);
    look(0, 0, 8'h00);
    cause(1, 1'b1);
    cause(1, 1'b0);
    stby <= 1'b1;
    tick(5);
    look(3, 0, 8'h00);
    stby <= 1'b0;
    tick(5);
    look(0, 0, 8'h00);
    cause(3, 1'b1);
    look(4, 0, 8'h00);
    cause(3, 1'b0);
    look(0, 0, 8'h00);
    for (int s = 0; s < 4; s++) begin
      rst;
      wr(ADDR_RESTART_CFG, 8'h20);
      wr(ADDR_SPEED_CFG, 8'(s << 2));
      sens <= 1'b1;
      lim = (s == 3) ? 40 : 1_000_000 / (OVSPD_LIMIT_HZ[s] * TICK_US) * TK;
      pulse(0, lim + 8);
      pulse(0, lim + 8);
      look(0, 0, 8'h00);
      pulse(0, lim / 2);
      pulse(0, 6);
      look(s == 3 ? 0 : 1, s != 3, s == 3 ? 8'h00 : 8'h04);
    end
    rst;
    wr(ADDR_RESTART_CFG, 8'h20);
    wr(ADDR_SPEED_CFG, 8'h03);
    wr(ADDR_LOCK_CFG, 8'h04);
    sens <= 1'b1;
    tick(10_000_000 / (128 * TICK_US) * TK - 40);
    look(0, 0, 8'h00);
    tick(60);
    look(2, 1, 8'h02);
    for (int d = 0; d < 2; d++) begin
      rst;
      wr(ADDR_RESTART_CFG, 8'h20);
      wr(ADDR_START_CFG, d ? 8'h80 : 8'h00);
      repeat (START_ROUNDS - 1) pulse(1, 6);
      look(0, 0, 8'h00);
      pulse(1, 6);
      look(d ? 0 : 1, d == 0, d ? 8'h00 : 8'h01);
    end
    rst;
    wr(ADDR_RESTART_CFG, 8'h20);
    cause(1, 1'b1);
    cause(1, 1'b0);
    tick(500_000 / TICK_US * TK - 200);
    look(1, 1, 8'h10);
    tick(300);
    look(0, 0, 8'h00);
    close_out();
  end
endmodule
